// [pmc_core_model.sv]
// Purpose: processor core issuing wait-for-interrupt sleep requests
// Assumes: mode field and wake setup already written by the bench
// Notes:   the request drops once the core is stopped or an interrupt comes,
//          so a refused request is held until an interrupt clears it
`timescale 1ns/1ps
module pmc_core_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // commands from the bench, and sleep status from the controller
  input  wire logic go_i,
  input  wire logic deep_i,
  input  wire logic irq_i,
  input  wire logic sleeping_i,
  // toward the controller
  output logic      wfi_req_o,
  output logic      deep_sleep_select_o,
  output logic      core_irq_o
);
  assign core_irq_o = irq_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wfi_req_o           <= 1'b0;
      deep_sleep_select_o <= 1'b0;
    end else if (go_i) begin
      wfi_req_o           <= 1'b1;
      deep_sleep_select_o <= deep_i;
    end else if (sleeping_i || irq_i) begin
      wfi_req_o <= 1'b0;
    end
  end
endmodule : pmc_core_model

// [pmc_pkg.sv]
// Purpose: shared constants and types for the power mode controller
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes:   offsets and field layouts are local choices
package pmc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_PWR_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SLEEP_CFG  = 8'h04;
  localparam logic [7:0] OFF_WAKE_CFG   = 8'h08;
  localparam logic [7:0] OFF_RUN_CFG    = 8'h0C;
  localparam logic [7:0] OFF_BUS_CLKEN  = 8'h10;
  localparam logic [7:0] OFF_CLK_SEL    = 8'h14;
  localparam logic [7:0] OFF_PIN_WAKE   = 8'h18;
  localparam logic [7:0] OFF_WAKE_EN1   = 8'h1C;
  localparam logic [7:0] OFF_DIV_CTRL   = 8'h20;
  localparam logic [7:0] OFF_STATUS     = 8'h24;

  // power control register fields
  localparam int PM_LSB        = 0;
  localparam int DPD_INHIBIT_B = 3;
  localparam int DPD_FLAG_B    = 11;

  // analog power bits: 1 = powered
  localparam int PWR_W     = 6;
  localparam int PWR_IRC   = 0;
  localparam int PWR_FLASH = 1;
  localparam int PWR_BOD   = 2;
  localparam int PWR_PLL   = 3;
  localparam int PWR_SOSC  = 4;
  localparam int PWR_WATCHDOG_OSC = 5;

  // wake enable register 1 fields
  localparam int WK_BOD  = 0;
  localparam int WK_WDT  = 1;
  localparam int WK_UART = 2;
  localparam int WK_I2C  = 3;
  localparam int WK_SPI  = 4;
  localparam int WK_W    = 5;

  localparam int PIN_W    = 8;
  localparam int BUSCLK_W = 20;
  localparam int BUSCLK_WDT = 17;

  localparam logic [PWR_W-1:0]    RUN_CFG_RST   = 6'h03;
  localparam logic [PWR_W-1:0]    SLEEP_CFG_RST = 6'h00;
  localparam logic [PWR_W-1:0]    WAKE_CFG_RST  = 6'h03;
  localparam logic [BUSCLK_W-1:0] BUSCLK_RST    = 20'h000DF;

  // divider fields: two 8-bit dividers, 0 stops the clock
  localparam int DIV_W = 8;

  // power mode field encodings
  typedef enum logic [1:0] {
    PM_SLEEP  = 2'h0,
    PM_DSLEEP = 2'h1,
    PM_PDOWN  = 2'h2,
    PM_DPD    = 2'h3
  } pmc_pm_t;

  // controller states
  typedef enum logic [2:0] {
    ST_ACTIVE  = 3'h0,
    ST_SLEEP   = 3'h1,
    ST_DEEP    = 3'h2,
    ST_WAKEPWR = 3'h3,
    ST_WAKECLK = 3'h4,
    ST_DPD     = 3'h5
  } pmc_state_t;

  // clock source select
  typedef enum logic [1:0] {
    CS_IRC   = 2'h0,
    CS_SOSC  = 2'h1,
    CS_WATCHDOG_OSC = 2'h2
  } pmc_clksrc_t;

  // wake sources from the peripherals
  typedef struct packed {
    logic [PIN_W-1:0] pin_irq;
    logic             bod_irq;
    logic             wdt_irq;
    logic             uart_irq;
    logic             uart_sync;
    logic             i2c_irq;
    logic             spi_irq;
  } pmc_wake_t;

  // gating outputs toward clock and analog blocks
  typedef struct packed {
    logic                core_clk_en;
    logic                main_clk_en;
    logic                irc_out_en;
    logic                flash_standby;
    logic                wdt_clk_en;
    logic                pins_hold;
    logic                debug_en;
    logic [PWR_W-1:0]    analog_pwr;
    logic [BUSCLK_W-1:0] periph_clk_en;
    logic [1:0]          clk_src;
    logic                uart_clk_en;
    logic                clock_output_pin_clk_en;
    logic                dpd_enter;
  } pmc_ctrl_t;

  localparam int STALL_CYC = 1;

endpackage : pmc_pkg

// [pmc_power_mode_controller.sv]
// Purpose: power mode controller sequencing active, sleep and deep modes
// Assumes: core signals wfi request with deep_sleep_select as levels
// Notes:   all outputs registered; one clock domain
// Operation
// RQ1: four reduced-power modes beyond active, each stopping different clocks
// RQ2: sleep entered by wfi with mode field zero and deep select clear
// RQ3: deep-sleep entered with mode field one, sleep config, deep select, wfi
// RQ4: software loads wake config and wake enables before deep-sleep
// RQ5: sleep stops the core clock until interrupt or reset
// RQ6: sleep keeps system clock and active power selections
// RQ7: bus-enabled peripherals run in sleep and their interrupts wake
// RQ8: sleep exits on enabled interrupt restoring run configuration; reset gives defaults
// RQ9: after reset active mode with run config and bus enable reset values
// RQ10: run config switches analog power; bus enables gate peripherals
// RQ11: system clock source selects irc, crystal or watchdog osc; irc default
// RQ12: serial and clock output clocks have own stoppable dividers
// RQ13: deep-sleep powers down analog except brown-out and watchdog osc per config
// RQ14: deep-sleep stops main and peripheral clocks; watchdog clock if osc selected
// RQ15: deep-sleep keeps irc running output gated; flash in standby
// RQ16: sleep modes retain state and hold pins static
// RQ17: any enabled pin interrupt of eight wakes from deep-sleep
// RQ18: brown-out interrupt wakes through wake enable one when kept powered
// RQ19: watchdog interrupt wakes through wake enable one when osc runs
// RQ20: serial port wakes only in synchronous mode; i2c and spi may wake
// RQ21: locked watchdog clock keeps watchdog osc powered in every reduced mode; code does so in deep-sleep and power-down only
// RQ22: debug unsupported in any reduced-power mode
// RQ23: power-down selected with mode field two before deep request
// RQ24: deep power-down selected with mode field three and inhibit clear
// RQ25: inhibit bit three in power control blocks deep power-down entry
// RQ26: deep wake applies wake config and main clock before core clock
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module pmc_power_mode_controller (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // ahb-lite slave
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic      [31:0]        hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  // processor core
  input  wire logic               wfi_req_i,
  input  wire logic               deep_sleep_select_i,
  input  wire logic               core_irq_i,
  input  wire logic               wdt_lock_i,
  // wake sources
  input  wire pmc_pkg::pmc_wake_t wake_i,
  // gating toward clock, oscillator and peripheral blocks
  output pmc_pkg::pmc_ctrl_t      ctrl_o,
  output logic                    sleeping_o
);

  // registers
  logic [1:0]                     power_mode_field_q;
  logic                           dpd_inhibit_q;
  logic                           dpd_flag_q;
  logic [pmc_pkg::PWR_W-1:0]      sleep_power_config_q;
  logic [pmc_pkg::PWR_W-1:0]      wake_power_config_q;
  logic [pmc_pkg::PWR_W-1:0]      run_power_config_q;
  logic [pmc_pkg::BUSCLK_W-1:0]   bus_clock_enables_q;
  logic [1:0]                     clk_sel_q;
  logic [pmc_pkg::PIN_W-1:0]      pin_wake_enables_q;
  logic [pmc_pkg::WK_W-1:0]       wake_en1_q;
  logic [pmc_pkg::DIV_W-1:0]      uart_div_q;
  logic [pmc_pkg::DIV_W-1:0]      clock_output_pin_div_q;
  pmc_pkg::pmc_state_t            state_q;
  pmc_pkg::pmc_state_t            state_d;
  pmc_pkg::pmc_ctrl_t             ctrl_d;
  logic                           wake_deep;
  logic                           watchdog_osc_keep;

  // bus address phase capture
  logic                           dph_valid_q;
  logic                           dph_write_q;
  logic [7:0]                     dph_addr_q;
  logic                           aph_take;

  assign aph_take = hsel_i & hready_i & htrans_i[1];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q  <= 8'h00;
    end else if (hready_i) begin
      dph_valid_q <= aph_take;
      dph_write_q <= hwrite_i;
      dph_addr_q  <= haddr_i[7:0];
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  logic wr;
  assign wr = dph_valid_q & dph_write_q;

  // software-written registers; reset gives active defaults
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_mode_field_q   <= 2'h0;
      dpd_inhibit_q        <= 1'b0;
      sleep_power_config_q <= pmc_pkg::SLEEP_CFG_RST;
      wake_power_config_q  <= pmc_pkg::WAKE_CFG_RST;
      run_power_config_q   <= pmc_pkg::RUN_CFG_RST;   // RQ9
      bus_clock_enables_q  <= pmc_pkg::BUSCLK_RST;    // RQ9
      clk_sel_q            <= pmc_pkg::CS_IRC;        // RQ11
      pin_wake_enables_q   <= 8'h00;
      wake_en1_q           <= 5'h00;
      uart_div_q           <= 8'h00;
      clock_output_pin_div_q         <= 8'h00;
    end else if (wr) begin
      case (dph_addr_q)
        pmc_pkg::OFF_PWR_CTRL: begin
          power_mode_field_q <= hwdata_i[pmc_pkg::PM_LSB +: 2];
          dpd_inhibit_q      <= hwdata_i[pmc_pkg::DPD_INHIBIT_B];
        end
        pmc_pkg::OFF_SLEEP_CFG: sleep_power_config_q <= hwdata_i[pmc_pkg::PWR_W-1:0];
        pmc_pkg::OFF_WAKE_CFG:  wake_power_config_q  <= hwdata_i[pmc_pkg::PWR_W-1:0];
        pmc_pkg::OFF_RUN_CFG:   run_power_config_q   <= hwdata_i[pmc_pkg::PWR_W-1:0];   // RQ10
        pmc_pkg::OFF_BUS_CLKEN: bus_clock_enables_q  <= hwdata_i[pmc_pkg::BUSCLK_W-1:0];
        pmc_pkg::OFF_CLK_SEL: begin
          // reserved encoding falls back to the rc oscillator
          clk_sel_q <= (hwdata_i[1:0] == 2'h3) ? 2'(pmc_pkg::CS_IRC) : hwdata_i[1:0];   // RQ11
        end
        pmc_pkg::OFF_PIN_WAKE:  pin_wake_enables_q   <= hwdata_i[pmc_pkg::PIN_W-1:0];
        pmc_pkg::OFF_WAKE_EN1:  wake_en1_q           <= hwdata_i[pmc_pkg::WK_W-1:0];
        pmc_pkg::OFF_DIV_CTRL: begin
          uart_div_q   <= hwdata_i[pmc_pkg::DIV_W-1:0];        // RQ12
          clock_output_pin_div_q <= hwdata_i[2*pmc_pkg::DIV_W-1:pmc_pkg::DIV_W];   // RQ12
        end
        default: ;
      endcase
    end
  end

  // deep power-down flag: set on entry, write one clears, set wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dpd_flag_q <= 1'b0;
    end else if (state_q != pmc_pkg::ST_DPD && state_d == pmc_pkg::ST_DPD) begin
      dpd_flag_q <= 1'b1;
    end else if (wr && dph_addr_q == pmc_pkg::OFF_PWR_CTRL && hwdata_i[pmc_pkg::DPD_FLAG_B]) begin
      dpd_flag_q <= 1'b0;
    end
  end

  // read data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (aph_take && !hwrite_i) begin
      case (haddr_i[7:0])
        pmc_pkg::OFF_PWR_CTRL:  hrdata_o <= {20'h00000, dpd_flag_q, 7'h00, dpd_inhibit_q, 1'b0,
                                             power_mode_field_q};
        pmc_pkg::OFF_SLEEP_CFG: hrdata_o <= {26'h0, sleep_power_config_q};
        pmc_pkg::OFF_WAKE_CFG:  hrdata_o <= {26'h0, wake_power_config_q};
        pmc_pkg::OFF_RUN_CFG:   hrdata_o <= {26'h0, run_power_config_q};
        pmc_pkg::OFF_BUS_CLKEN: hrdata_o <= {12'h000, bus_clock_enables_q};
        pmc_pkg::OFF_CLK_SEL:   hrdata_o <= {30'h0, clk_sel_q};
        pmc_pkg::OFF_PIN_WAKE:  hrdata_o <= {24'h000000, pin_wake_enables_q};
        pmc_pkg::OFF_WAKE_EN1:  hrdata_o <= {27'h0, wake_en1_q};
        pmc_pkg::OFF_DIV_CTRL:  hrdata_o <= {16'h0000, clock_output_pin_div_q, uart_div_q};
        pmc_pkg::OFF_STATUS:    hrdata_o <= {29'h0, state_q};
        default:                hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // deep wake sources; core_irq plays no part in leaving deep-sleep
  always_comb begin
    wake_deep = |(wake_i.pin_irq & pin_wake_enables_q);   // RQ17
    wake_deep = wake_deep | (wake_i.bod_irq & wake_en1_q[pmc_pkg::WK_BOD]
                             & sleep_power_config_q[pmc_pkg::PWR_BOD]);   // RQ18
    wake_deep = wake_deep | (wake_i.wdt_irq & wake_en1_q[pmc_pkg::WK_WDT] & watchdog_osc_keep
                             & bus_clock_enables_q[pmc_pkg::BUSCLK_WDT]);   // RQ19
    wake_deep = wake_deep | (wake_i.uart_irq & wake_i.uart_sync & wake_en1_q[pmc_pkg::WK_UART]);   // RQ20
    wake_deep = wake_deep | (wake_i.i2c_irq & wake_en1_q[pmc_pkg::WK_I2C])
                          | (wake_i.spi_irq & wake_en1_q[pmc_pkg::WK_SPI]);   // RQ20
  end

  // watchdog osc kept on by lock regardless of sleep config
  assign watchdog_osc_keep = sleep_power_config_q[pmc_pkg::PWR_WATCHDOG_OSC] | wdt_lock_i;   // RQ21

  // mode sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      pmc_pkg::ST_ACTIVE: begin
        if (wfi_req_i && !core_irq_i) begin
          if (!deep_sleep_select_i) begin
            state_d = pmc_pkg::ST_SLEEP;   // RQ2
          end else if (power_mode_field_q == pmc_pkg::PM_DPD) begin
            // inhibited deep power-down request is ignored, core keeps running
            state_d = dpd_inhibit_q ? pmc_pkg::ST_ACTIVE : pmc_pkg::ST_DPD;   // RQ25
          end else begin
            state_d = pmc_pkg::ST_DEEP;   // RQ3
          end
        end
      end
      pmc_pkg::ST_SLEEP:   state_d = core_irq_i ? pmc_pkg::ST_ACTIVE : pmc_pkg::ST_SLEEP;   // RQ8
      pmc_pkg::ST_DEEP:    state_d = wake_deep ? pmc_pkg::ST_WAKEPWR : pmc_pkg::ST_DEEP;
      pmc_pkg::ST_WAKEPWR: state_d = pmc_pkg::ST_WAKECLK;   // RQ26
      pmc_pkg::ST_WAKECLK: state_d = pmc_pkg::ST_ACTIVE;    // RQ26
      // left only by chip reset
      pmc_pkg::ST_DPD:     state_d = pmc_pkg::ST_DPD;
      default:             state_d = pmc_pkg::ST_ACTIVE;
    endcase
  end

  logic [1:0] deep_mode_q;
  logic [1:0] deep_mode;

  // the entry edge must already see the mode just requested, not the one kept from the last entry
  assign deep_mode = (state_q == pmc_pkg::ST_ACTIVE) ? power_mode_field_q : deep_mode_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q     <= pmc_pkg::ST_ACTIVE;   // RQ9
      deep_mode_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_q == pmc_pkg::ST_ACTIVE && state_d == pmc_pkg::ST_DEEP) begin
        deep_mode_q <= power_mode_field_q;
      end
    end
  end

  // gating outputs per state
  always_comb begin
    ctrl_d               = '0;
    ctrl_d.clk_src       = clk_sel_q;
    ctrl_d.uart_clk_en   = (uart_div_q != 8'h00);     // RQ12
    ctrl_d.clock_output_pin_clk_en = (clock_output_pin_div_q != 8'h00);   // RQ12
    case (state_d)
      pmc_pkg::ST_ACTIVE: begin
        ctrl_d.core_clk_en   = 1'b1;
        ctrl_d.main_clk_en   = 1'b1;
        ctrl_d.irc_out_en    = 1'b1;
        ctrl_d.wdt_clk_en    = 1'b1;
        ctrl_d.debug_en      = 1'b1;
        ctrl_d.analog_pwr    = run_power_config_q;    // RQ10
        ctrl_d.periph_clk_en = bus_clock_enables_q;   // RQ10
      end
      pmc_pkg::ST_SLEEP: begin
        // core and debug stopped, pins held, everything else as in active
        ctrl_d.main_clk_en   = 1'b1;                  // RQ6
        ctrl_d.irc_out_en    = 1'b1;
        ctrl_d.wdt_clk_en    = 1'b1;
        ctrl_d.analog_pwr    = run_power_config_q;    // RQ6
        ctrl_d.periph_clk_en = bus_clock_enables_q;   // RQ7
        ctrl_d.pins_hold     = 1'b1;                  // RQ16
      end
      pmc_pkg::ST_DEEP: begin
        ctrl_d.analog_pwr[pmc_pkg::PWR_BOD]   = sleep_power_config_q[pmc_pkg::PWR_BOD];   // RQ13
        ctrl_d.analog_pwr[pmc_pkg::PWR_WATCHDOG_OSC] = watchdog_osc_keep;   // RQ13
        // power-down also drops the rc oscillator and flash
        ctrl_d.analog_pwr[pmc_pkg::PWR_IRC]   = (deep_mode == pmc_pkg::PM_DSLEEP);   // RQ15
        ctrl_d.analog_pwr[pmc_pkg::PWR_FLASH] = (deep_mode == pmc_pkg::PM_DSLEEP);
        ctrl_d.flash_standby = (deep_mode == pmc_pkg::PM_DSLEEP);   // RQ15
        ctrl_d.wdt_clk_en    = watchdog_osc_keep;   // RQ14
        ctrl_d.pins_hold     = 1'b1;         // RQ16
      end
      pmc_pkg::ST_WAKEPWR: begin
        // power back up first, main and core clocks still off
        ctrl_d.analog_pwr = wake_power_config_q;   // RQ26
        ctrl_d.wdt_clk_en = watchdog_osc_keep;
        ctrl_d.pins_hold  = 1'b1;
      end
      pmc_pkg::ST_WAKECLK: begin
        ctrl_d.analog_pwr    = wake_power_config_q;   // RQ26
        ctrl_d.main_clk_en   = 1'b1;                  // RQ26
        ctrl_d.irc_out_en    = 1'b1;
        ctrl_d.wdt_clk_en    = 1'b1;
        ctrl_d.periph_clk_en = bus_clock_enables_q;
        ctrl_d.pins_hold     = 1'b1;
      end
      pmc_pkg::ST_DPD: begin
        ctrl_d.dpd_enter = 1'b1;   // RQ1
      end
      default: ;
    endcase
    if (state_d != pmc_pkg::ST_ACTIVE) begin
      ctrl_d.uart_clk_en   = ctrl_d.uart_clk_en & ctrl_d.main_clk_en;
      ctrl_d.clock_output_pin_clk_en = ctrl_d.clock_output_pin_clk_en & ctrl_d.main_clk_en;   // RQ14
    end
  end

  // run config is left unchanged by a deep wake; active mode applies it again
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_o     <= '0;
      sleeping_o <= 1'b0;
    end else begin
      ctrl_o     <= ctrl_d;   // RQ5 RQ22
      sleeping_o <= (state_d != pmc_pkg::ST_ACTIVE);
    end
  end

endmodule : pmc_power_mode_controller

// [pmc_properties.sv]
// Purpose: concurrent checks on the power mode controller ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   deep-sleep is recognised by flash standby, the only state that sets it
`timescale 1ns/1ps
module pmc_properties (
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  // core side
  input wire logic               deep_sleep_select_i,
  input wire logic               core_irq_i,
  input wire logic               wdt_lock_i,
  // gating outputs
  input wire pmc_pkg::pmc_ctrl_t ctrl_o,
  input wire logic               sleeping_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_core_off; sleeping_o |-> !ctrl_o.core_clk_en; endproperty
  a_core_off: assert property (p_core_off) else $error("core clock runs while asleep");
  property p_no_debug; sleeping_o |-> !ctrl_o.debug_en; endproperty
  a_no_debug: assert property (p_no_debug) else $error("debug enabled while asleep");
  property p_sleep_exit; sleeping_o && ctrl_o.main_clk_en && core_irq_i |=> !sleeping_o; endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left on interrupt");
  property p_sleep_keep;
    $rose(sleeping_o) && !$past(deep_sleep_select_i)
      |-> ctrl_o.main_clk_en && ctrl_o.periph_clk_en == $past(ctrl_o.periph_clk_en);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("sleep changed system clocks");
  property p_deep_off; ctrl_o.flash_standby |-> !ctrl_o.main_clk_en && !ctrl_o.irc_out_en && ctrl_o.periph_clk_en == '0; endproperty
  a_deep_off: assert property (p_deep_off) else $error("clock left on in deep-sleep");
  property p_deep_analog; ctrl_o.flash_standby |-> (ctrl_o.analog_pwr & 6'h18) == 6'h00; endproperty
  a_deep_analog: assert property (p_deep_analog) else $error("pll or crystal powered in deep-sleep");
  property p_lock; wdt_lock_i && ctrl_o.flash_standby |-> ctrl_o.analog_pwr[pmc_pkg::PWR_WATCHDOG_OSC]; endproperty
  a_lock: assert property (p_lock) else $error("locked watchdog osc powered down");
  property p_wake_order; $rose(ctrl_o.core_clk_en) && $past(sleeping_o) |-> $past(ctrl_o.main_clk_en); endproperty
  a_wake_order: assert property (p_wake_order) else $error("core clock before main clock");
  property p_pins; $rose(sleeping_o) && !ctrl_o.dpd_enter |-> ctrl_o.pins_hold; endproperty
  a_pins: assert property (p_pins) else $error("pins not held on sleep entry");
  property p_active; !sleeping_o && $past(rst_n_i) |-> ctrl_o.core_clk_en && ctrl_o.main_clk_en; endproperty
  a_active: assert property (p_active) else $error("active mode without clocks");
endmodule : pmc_properties

bind pmc_power_mode_controller pmc_properties i_pmc_properties (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .deep_sleep_select_i(deep_sleep_select_i),
  .core_irq_i(core_irq_i), .wdt_lock_i(wdt_lock_i), .ctrl_o(ctrl_o), .sleeping_o(sleeping_o));

// [power_mode_controller_bench.sv]
// Purpose: self-checking bench for the power mode controller
// Assumes: bus slave answers at once; core model drives wfi requests
// Notes:   wake edges are counted from the edge that samples the source
`timescale 1ns/1ps
module power_mode_controller_bench;
  logic               clk_i, rst_n_i, hsel, hwrite, go, deep, irq, lock;
  logic [31:0]        haddr, hwdata, hrdata, q;
  logic [1:0]         htrans;
  logic               hreadyout, hresp, sleeping, wait_for_interrupt_instr, dsel, cirq;
  pmc_pkg::pmc_wake_t wake, w;
  pmc_pkg::pmc_ctrl_t ctrl;
  int                 error_cnt, num_checks, n, b;

  pmc_power_mode_controller i_pmc_power_mode_controller (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .wfi_req_i(wait_for_interrupt_instr),
    .deep_sleep_select_i(dsel), .core_irq_i(cirq), .wdt_lock_i(lock), .wake_i(wake), .ctrl_o(ctrl),
    .sleeping_o(sleeping));
  pmc_core_model i_pmc_core_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .deep_i(deep), .irq_i(irq),
    .sleeping_i(sleeping), .wfi_req_o(wait_for_interrupt_instr), .deep_sleep_select_o(dsel), .core_irq_o(cirq));

  always #2.5 clk_i = ~clk_i;

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic hang(input string s);
    error_cnt++;
    $display("unexpected timeout in %s", s);
    summarize();
  endtask : hang
  // address phase, then data phase; each held until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h000000, a}; hwrite <= wr;
    k = 0;
    do begin @(posedge clk_i); k++; end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) hang("bus");
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (hreadyout !== 1'b1 && k < 20);
    q = hrdata;
    if (k >= 20) hang("bus");
  endtask : bus
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic wait_slp(input logic v);
    int k;
    k = 0;
    while (sleeping !== v && k < 50) begin @(posedge clk_i); #1; k++; end
    if (k >= 50) hang("sleep wait");
  endtask : wait_slp
  task automatic enter(input logic d);
    @(posedge clk_i); go <= 1'b1; deep <= d;
    @(posedge clk_i); go <= 1'b0;
    wait_slp(1'b1);
  endtask : enter
  task automatic do_reset();
    @(posedge clk_i); rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i); #1;
  endtask : do_reset

  initial begin
    clk_i = 0; rst_n_i = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    go = 0; deep = 0; irq = 0; lock = 0; wake = '0; error_cnt = 0; num_checks = 0;
    do_reset();
    chk("core_clk", 1, ctrl.core_clk_en);
    chk("analog", pmc_pkg::RUN_CFG_RST, ctrl.analog_pwr);
    chk("periph", pmc_pkg::BUSCLK_RST, ctrl.periph_clk_en);
    chk("clk_src", pmc_pkg::CS_IRC, ctrl.clk_src);
    bus(0, pmc_pkg::OFF_RUN_CFG, 0); chk("run_cfg", pmc_pkg::RUN_CFG_RST, q);
    bus(0, pmc_pkg::OFF_BUS_CLKEN, 0); chk("bus_en", pmc_pkg::BUSCLK_RST, q);
    bus(0, 8'h30, 0); chk("unmapped", 0, q);
    bus(1, pmc_pkg::OFF_RUN_CFG, 32'h3F); bus(1, pmc_pkg::OFF_BUS_CLKEN, 32'hFFFFF); settle();
    chk("analog", 32'h3F, ctrl.analog_pwr);
    chk("periph", 32'hFFFFF, ctrl.periph_clk_en);
    for (int k = 2; k >= 0; k--) begin
      bus(1, pmc_pkg::OFF_CLK_SEL, k); settle(); chk("clk_src", k, ctrl.clk_src);
    end
    bus(1, pmc_pkg::OFF_DIV_CTRL, 32'h100); settle();
    chk("div_stop", 32'h1, {ctrl.uart_clk_en, ctrl.clock_output_pin_clk_en});
    bus(1, pmc_pkg::OFF_DIV_CTRL, 32'h1); settle();
    chk("div_run", 32'h1, {ctrl.clock_output_pin_clk_en, ctrl.uart_clk_en});
    bus(1, pmc_pkg::OFF_PWR_CTRL, pmc_pkg::PM_SLEEP); enter(0);
    chk("sleep", 32'h2, {ctrl.main_clk_en, ctrl.core_clk_en});
    chk("sleep_analog", 32'h3F, ctrl.analog_pwr);
    @(posedge clk_i); irq <= 1'b1;
    wait_slp(0);
    chk("wake_core", 1, ctrl.core_clk_en);
    @(posedge clk_i); irq <= 1'b0;
    bus(1, pmc_pkg::OFF_PWR_CTRL, pmc_pkg::PM_DSLEEP);
    bus(1, pmc_pkg::OFF_SLEEP_CFG, 32'h4); bus(1, pmc_pkg::OFF_WAKE_CFG, 32'h3F);
    for (int i = 0; i < 8; i++) begin
      bus(1, pmc_pkg::OFF_PIN_WAKE, 32'(1 << i));
      @(posedge clk_i); lock <= (i == 3);
      enter(1);
      chk("deep_clk", 32'h2, {ctrl.flash_standby, ctrl.main_clk_en});
      chk("deep_analog", (i == 3) ? 32'h24 : 32'h4, ctrl.analog_pwr & 6'h3C);
      @(posedge clk_i); wake.pin_irq <= 8'(1 << ((i + 1) % 8));
      repeat (5) @(posedge clk_i);
      #1 chk("pin_off", 1, sleeping);
      @(posedge clk_i); wake.pin_irq <= 8'(1 << i);
      n = 0;
      do begin @(posedge clk_i); #1; n++; end while (ctrl.core_clk_en !== 1'b1 && n < 20);
      if (n >= 20) hang("deep wake");
      chk("wake_edges", 3, n);
      @(posedge clk_i); wake.pin_irq <= 8'h00; lock <= 1'b0;
    end
    bus(1, pmc_pkg::OFF_SLEEP_CFG, 32'h24); bus(1, pmc_pkg::OFF_PIN_WAKE, 32'h1);
    // asynchronous serial without sync mode must not wake; a pin rescues it
    for (int k = 0; k < 6; k++) begin
      w = '0;
      case (k)
        0: w.bod_irq = 1'b1;
        1: w.wdt_irq = 1'b1;
        2: begin w.uart_irq = 1'b1; w.uart_sync = 1'b1; end
        3: w.uart_irq = 1'b1;
        4: w.i2c_irq = 1'b1;
        default: w.spi_irq = 1'b1;
      endcase
      b = (k < 3) ? k : k - 1;
      bus(1, pmc_pkg::OFF_WAKE_EN1, 32'(1 << b));
      enter(1);
      @(posedge clk_i); wake <= w;
      repeat (6) @(posedge clk_i);
      #1 chk("src_wake", (k == 3) ? 1 : 0, sleeping);
      w = '0;
      w.pin_irq = 8'h01;
      @(posedge clk_i); wake <= w;
      wait_slp(0);
      @(posedge clk_i); wake <= '0;
    end
    bus(1, pmc_pkg::OFF_PWR_CTRL, pmc_pkg::PM_PDOWN); enter(1);
    chk("pdown_irc", 0, ctrl.analog_pwr[pmc_pkg::PWR_IRC]);
    @(posedge clk_i); wake.pin_irq <= 8'h01;
    wait_slp(0);
    @(posedge clk_i); wake.pin_irq <= 8'h00;
    bus(1, pmc_pkg::OFF_PWR_CTRL, 32'h8 | pmc_pkg::PM_DPD);
    @(posedge clk_i); go <= 1'b1; deep <= 1'b1;
    @(posedge clk_i); go <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1 chk("dpd_inhibit", 0, sleeping);
    @(posedge clk_i); irq <= 1'b1;
    @(posedge clk_i); irq <= 1'b0;
    bus(1, pmc_pkg::OFF_PWR_CTRL, pmc_pkg::PM_DPD); enter(1);
    chk("dpd_enter", 1, ctrl.dpd_enter);
    do_reset();
    chk("reset_active", 0, sleeping);
    chk("reset_analog", pmc_pkg::RUN_CFG_RST, ctrl.analog_pwr);
    summarize();
  end
endmodule : power_mode_controller_bench
